// ### src/async_timer2.v
// 8-bit timer/counter with optional asynchronous clocking
// assumes a byte register port in the ref_clk domain; the oscillator
// pin is sampled as an ordinary input and its rising edges become ticks
`timescale 1ns/1ps
`include "timer2_consts.vh"

module async_timer2 (
  // clock and reset
  input wire ref_clk,
  input wire rst,
  // register port
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire wr_en,
  input wire rd_en,
  output reg [7:0] rdata,
  // interrupt controller
  input wire global_irq_enable,
  input wire [2:0] vector_ack,
  output wire irq_compare_b,
  output wire irq_compare_a,
  output wire irq_overflow,
  // oscillator pin
  input wire osc_input_pin,
  output wire osc_run,
  output wire ext_clk_buf_en,
  // waveform pins
  output wire wave_out_a,
  output wire wave_out_a_oe,
  output wire wave_out_b,
  output wire wave_out_b_oe
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  reg [7:0] ctrl_a_t_r;
  reg [3:0] ctrl_b_t_r;
  reg [7:0] cmp_a_t_r;
  reg [7:0] cmp_b_t_r;
  reg [7:0] cnt_t_r;
  reg [7:0] ctrl_a_r;
  reg [3:0] ctrl_b_r;
  reg [7:0] cmp_a_r;
  reg [7:0] cmp_b_r;
  reg [7:0] count_r;
  reg [4:0] pend_r;
  reg ext_clk_r;
  reg async_sel_r;
  reg [2:0] irq_en_r;
  reg [2:0] flag_r;
  reg up_r;
  reg block_r;
  reg wave_a_r;
  reg wave_b_r;
  reg osc_s1_r;
  reg osc_s2_r;
  reg osc_s3_r;
  reg [7:0] count_nxt;
  reg up_nxt;
  reg [7:0] rd_nxt;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire wr_irq = wr_en && (addr == `OFS_IRQ_ENABLE);
  wire wr_ctl_a = wr_en && (addr == `OFS_CTRL_A);
  wire wr_ctl_b = wr_en && (addr == `OFS_CTRL_B);
  wire wr_cnt = wr_en && (addr == `OFS_COUNT);
  wire wr_cmp_a = wr_en && (addr == `OFS_CMP_A);
  wire wr_cmp_b = wr_en && (addr == `OFS_CMP_B);
  wire wr_async = wr_en && (addr == `OFS_ASYNC);
  wire wr_flags = wr_en && (addr == `OFS_FLAGS);

  // ----------------------------------------
  // tick source
  // ----------------------------------------
  // the second and third stages feed the edge detector
  wire osc_edge = osc_s2_r & ~osc_s3_r;
  // in async mode a transfer waits for an oscillator edge
  wire xfer = osc_edge;
  wire src_tick = async_sel_r ? osc_edge : 1'b1;
  wire tick;

  tick_prescaler u_prescaler (
    .ref_clk(ref_clk),
    .rst(rst),
    .src_tick(src_tick),
    .sel(ctrl_b_r[2:0]),
    .tick(tick)
  );

  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  wire [2:0] wgm = {ctrl_b_r[`CB_WGM_MSB], ctrl_a_r[1:0]};
  wire pwm = wgm[0];
  wire phase_pwm = (wgm[1:0] == 2'b01);
  wire top_is_cmp = wgm[2] | (wgm == 3'b010);
  wire [7:0] top = top_is_cmp ? cmp_a_r : `COUNT_MAX;
  wire at_top = (count_r == top);
  wire at_bottom = (count_r == `COUNT_BOTTOM);

  // a counter load blocks the match on the following tick
  wire match_a = tick && (count_r == cmp_a_r) && !block_r;
  wire match_b = tick && (count_r == cmp_b_r) && !block_r;
  // in PWM modes the written strobes are dropped
  wire force_a = wr_ctl_b && wdata[`CB_FORCE_A] && !pwm;
  wire force_b = wr_ctl_b && wdata[`CB_FORCE_B] && !pwm;
  wire fast_bottom = tick && pwm && !phase_pwm && at_top;

  reg ovf_evt;
  always @* begin
    if (phase_pwm) begin
      ovf_evt = tick && at_bottom && !up_r;
    end else if (pwm) begin
      ovf_evt = tick && at_top;
    end else begin
      ovf_evt = tick && (count_r == `COUNT_MAX);
    end
  end

  // ----------------------------------------
  // counting sequence
  // ----------------------------------------
  always @* begin
    count_nxt = count_r;
    up_nxt = up_r;
    if (phase_pwm) begin
      if (up_r) begin
        if (at_top) begin
          up_nxt = 1'b0;
          count_nxt = count_r - 8'h01;
        end else begin
          count_nxt = count_r + 8'h01;
        end
      end else begin
        if (at_bottom) begin
          up_nxt = 1'b1;
          count_nxt = count_r + 8'h01;
        end else begin
          count_nxt = count_r - 8'h01;
        end
      end
    end else if (at_top) begin
      count_nxt = `COUNT_BOTTOM;
      up_nxt = 1'b1;
    end else begin
      count_nxt = count_r + 8'h01;
      up_nxt = 1'b1;
    end
  end

  // ----------------------------------------
  // waveform output update
  // ----------------------------------------
  function wave_nxt;
    input cur;
    input [1:0] act;
    input m;
    input f;
    input [2:0] mode;
    input up;
    input bot;
    begin
      wave_nxt = cur;
      if (!mode[0]) begin
        if (m || f) begin
          case (act)
            2'd1: wave_nxt = ~cur;
            2'd2: wave_nxt = 1'b0;
            2'd3: wave_nxt = 1'b1;
            default: wave_nxt = cur;
          endcase
        end
      end else if (act == 2'd1) begin
        if (m && mode[2]) begin
          wave_nxt = ~cur;
        end
      end else if (act[1]) begin
        if (mode[1]) begin
          if (m) begin
            wave_nxt = act[0];
          end else if (bot) begin
            wave_nxt = ~act[0];
          end
        end else if (m) begin
          wave_nxt = up ? act[0] : ~act[0];
        end
      end
    end
  endfunction

  // ----------------------------------------
  // pin synchroniser
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (rst) begin
      osc_s1_r <= 1'b0;
      osc_s2_r <= 1'b0;
      osc_s3_r <= 1'b0;
    end else begin
      osc_s1_r <= osc_input_pin;
      osc_s2_r <= osc_s1_r;
      osc_s3_r <= osc_s2_r;
    end
  end

  // ----------------------------------------
  // software-facing registers
  // ----------------------------------------
  always @(posedge ref_clk) begin
    if (rst) begin
      ctrl_a_t_r <= `RST_BYTE;
      ctrl_b_t_r <= 4'h0;
      cmp_a_t_r <= `RST_BYTE;
      cmp_b_t_r <= `RST_BYTE;
      cnt_t_r <= `RST_BYTE;
      irq_en_r <= 3'h0;
      ext_clk_r <= 1'b0;
      async_sel_r <= 1'b0;
    end else begin
      if (wr_ctl_a) begin
        ctrl_a_t_r <= {wdata[7:4], 2'b00, wdata[1:0]};
      end
      if (wr_ctl_b) begin
        ctrl_b_t_r <= wdata[3:0];
      end
      if (wr_cmp_a) begin
        cmp_a_t_r <= wdata;
      end
      if (wr_cmp_b) begin
        cmp_b_t_r <= wdata;
      end
      if (wr_cnt) begin
        cnt_t_r <= wdata;
      end
      if (wr_irq) begin
        irq_en_r <= wdata[2:0];
      end
      if (wr_async) begin
        ext_clk_r <= wdata[`AS_EXT_CLK];
        async_sel_r <= wdata[`AS_ASYNC_SEL];
      end
    end
  end

  // ----------------------------------------
  // busy flags and transfer into the timer
  // ----------------------------------------
  // a write landing with a transfer keeps its flag: set beats clear
  wire [4:0] wr_vec = {wr_cnt, wr_cmp_a, wr_cmp_b, wr_ctl_a, wr_ctl_b};

  always @(posedge ref_clk) begin
    if (rst) begin
      pend_r <= 5'h00;
    end else if (async_sel_r) begin
      pend_r <= wr_vec | (pend_r & {5{~xfer}});
    end else begin
      pend_r <= 5'h00;
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      ctrl_a_r <= `RST_BYTE;
      ctrl_b_r <= 4'h0;
      cmp_a_r <= `RST_BYTE;
      cmp_b_r <= `RST_BYTE;
    end else if (!async_sel_r) begin
      if (wr_ctl_a) begin
        ctrl_a_r <= {wdata[7:4], 2'b00, wdata[1:0]};
      end
      if (wr_ctl_b) begin
        ctrl_b_r <= wdata[3:0];
      end
      if (wr_cmp_a) begin
        cmp_a_r <= wdata;
      end
      if (wr_cmp_b) begin
        cmp_b_r <= wdata;
      end
    end else if (xfer) begin
      if (pend_r[`PEND_CTRL_A]) begin
        ctrl_a_r <= ctrl_a_t_r;
      end
      if (pend_r[`PEND_CTRL_B]) begin
        ctrl_b_r <= ctrl_b_t_r;
      end
      if (pend_r[`PEND_CMP_A]) begin
        cmp_a_r <= cmp_a_t_r;
      end
      if (pend_r[`PEND_CMP_B]) begin
        cmp_b_r <= cmp_b_t_r;
      end
    end
  end

  // ----------------------------------------
  // counter
  // ----------------------------------------
  wire load_sync = wr_cnt && !async_sel_r;
  wire load_async = async_sel_r && xfer && pend_r[`PEND_COUNT];

  always @(posedge ref_clk) begin
    if (rst) begin
      count_r <= `RST_BYTE;
      up_r <= 1'b1;
      block_r <= 1'b0;
    end else if (load_sync) begin
      count_r <= wdata;
      block_r <= 1'b1;
    end else if (load_async) begin
      count_r <= cnt_t_r;
      block_r <= 1'b1;
    end else if (tick) begin
      count_r <= count_nxt;
      up_r <= up_nxt;
      block_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // waveform outputs
  // ----------------------------------------
  // forced events reach only the pins, never the flags or counter
  always @(posedge ref_clk) begin
    if (rst) begin
      wave_a_r <= 1'b0;
      wave_b_r <= 1'b0;
    end else begin
      wave_a_r <= wave_nxt(wave_a_r,
        ctrl_a_r[`CA_ACT_A_HI:`CA_ACT_A_LO], match_a, force_a, wgm,
        up_r, fast_bottom);
      wave_b_r <= wave_nxt(wave_b_r,
        ctrl_a_r[`CA_ACT_B_HI:`CA_ACT_B_LO], match_b, force_b, wgm,
        up_r, fast_bottom);
    end
  end

  assign wave_out_a = wave_a_r;
  assign wave_out_b = wave_b_r;
  assign wave_out_a_oe = |ctrl_a_r[`CA_ACT_A_HI:`CA_ACT_A_LO];
  assign wave_out_b_oe = |ctrl_a_r[`CA_ACT_B_HI:`CA_ACT_B_LO];

  // ----------------------------------------
  // interrupt flags
  // ----------------------------------------
  wire [2:0] flag_set = {match_b, match_a, ovf_evt};
  wire [2:0] flag_clr = vector_ack | (wr_flags ? wdata[2:0] : 3'h0);

  always @(posedge ref_clk) begin
    if (rst) begin
      flag_r <= 3'h0;
    end else begin
      flag_r <= flag_set | (flag_r & ~flag_clr);
    end
  end

  assign irq_compare_b = global_irq_enable
    & irq_en_r[`IRQ_CMP_B] & flag_r[`IRQ_CMP_B];
  assign irq_compare_a = global_irq_enable
    & irq_en_r[`IRQ_CMP_A] & flag_r[`IRQ_CMP_A];
  assign irq_overflow = global_irq_enable
    & irq_en_r[`IRQ_OVF] & flag_r[`IRQ_OVF];

  // ----------------------------------------
  // oscillator control
  // ----------------------------------------
  // the crystal is held off whenever the input buffer is in use
  assign osc_run = async_sel_r & ~ext_clk_r;
  assign ext_clk_buf_en = async_sel_r & ext_clk_r;

  // ----------------------------------------
  // read port
  // ----------------------------------------
  always @* begin
    if (addr == `OFS_IRQ_ENABLE) begin
      rd_nxt = {5'h00, irq_en_r};
    end else if (addr == `OFS_CTRL_A) begin
      rd_nxt = ctrl_a_t_r;
    end else if (addr == `OFS_CTRL_B) begin
      rd_nxt = {4'h0, ctrl_b_t_r};
    end else if (addr == `OFS_COUNT) begin
      rd_nxt = count_r;
    end else if (addr == `OFS_CMP_A) begin
      rd_nxt = cmp_a_t_r;
    end else if (addr == `OFS_CMP_B) begin
      rd_nxt = cmp_b_t_r;
    end else if (addr == `OFS_ASYNC) begin
      rd_nxt = {1'b0, ext_clk_r, async_sel_r, pend_r};
    end else if (addr == `OFS_FLAGS) begin
      rd_nxt = {5'h00, flag_r};
    end else begin
      rd_nxt = 8'h00;
    end
  end

  // data stands only in the cycle after the strobe
  always @(posedge ref_clk) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (rd_en) begin
      rdata <= rd_nxt;
    end else begin
      rdata <= 8'h00;
    end
  end

endmodule

// ### src/tick_prescaler.v
// timer tick prescaler: divides a source tick by the selected ratio
// assumes src_tick is a one-cycle pulse in the ref_clk domain
`timescale 1ns/1ps
`include "timer2_consts.vh"

module tick_prescaler (
  // clock and reset
  input wire ref_clk,
  input wire rst,
  // source and selection
  input wire src_tick,
  input wire [2:0] sel,
  // divided tick
  output reg tick
);

  reg [9:0] div_r;
  reg [9:0] mask;

  // ----------------------------------------
  // tap selection
  // ----------------------------------------
  always @* begin
    case (sel)
      3'd2: mask = `PS_MASK_8;
      3'd3: mask = `PS_MASK_32;
      3'd4: mask = `PS_MASK_64;
      3'd5: mask = `PS_MASK_128;
      3'd6: mask = `PS_MASK_256;
      3'd7: mask = `PS_MASK_1024;
      default: mask = 10'h000;
    endcase
  end

  // free-running divider, shared by all taps
  always @(posedge ref_clk) begin
    if (rst) begin
      div_r <= 10'h000;
    end else if (src_tick) begin
      div_r <= div_r + 10'h001;
    end
  end

  // code 0 stops the counter, code 1 passes every source tick
  always @* begin
    tick = src_tick && (sel != 3'd0) && ((div_r & mask) == mask);
  end

endmodule

// ### src/timer2_consts.vh
// register map, field positions, reset values and prescaler masks
// assumes byte-wide registers on an 8-bit address bus
`ifndef TIMER2_CONSTS_VH
`define TIMER2_CONSTS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_IRQ_ENABLE 8'h70
`define OFS_CTRL_A 8'hB0
`define OFS_CTRL_B 8'hB1
`define OFS_COUNT 8'hB2
`define OFS_CMP_A 8'hB3
`define OFS_CMP_B 8'hB4
`define OFS_ASYNC 8'hB6
`define OFS_FLAGS 8'h37

// ----------------------------------------
// field positions
// ----------------------------------------
`define CB_FORCE_A 7
`define CB_FORCE_B 6
`define CB_WGM_MSB 3
`define CA_ACT_A_HI 7
`define CA_ACT_A_LO 6
`define CA_ACT_B_HI 5
`define CA_ACT_B_LO 4
`define AS_EXT_CLK 6
`define AS_ASYNC_SEL 5
`define IRQ_CMP_B 2
`define IRQ_CMP_A 1
`define IRQ_OVF 0
`define PEND_COUNT 4
`define PEND_CMP_A 3
`define PEND_CMP_B 2
`define PEND_CTRL_A 1
`define PEND_CTRL_B 0

// ----------------------------------------
// reset values and counter limits
// ----------------------------------------
`define RST_BYTE 8'h00
`define COUNT_MAX 8'hFF
`define COUNT_BOTTOM 8'h00

// ----------------------------------------
// prescaler tap masks (divide by mask + 1)
// ----------------------------------------
`define PS_MASK_8 10'h007
`define PS_MASK_32 10'h01F
`define PS_MASK_64 10'h03F
`define PS_MASK_128 10'h07F
`define PS_MASK_256 10'h0FF
`define PS_MASK_1024 10'h3FF

`endif

// ### tb/async_timer2_sva.sv
// concurrent checks on the timer's register port and pins
// assumes it is bound to async_timer2 and sees only its ports
`timescale 1ns/1ps
`include "timer2_consts.vh"

module timer2_checker (
  // clock and reset
  input wire ref_clk,
  input wire rst,
  // register port
  input wire [7:0] addr,
  input wire [7:0] wdata,
  input wire wr_en,
  input wire rd_en,
  input wire [7:0] rdata,
  // interrupts
  input wire global_irq_enable,
  input wire irq_compare_b,
  input wire irq_compare_a,
  input wire irq_overflow,
  // pins
  input wire osc_run,
  input wire ext_clk_buf_en,
  input wire wave_out_a
);
  // ----------------------------------------
  // shadow of software writes
  // ----------------------------------------
  // mirrors hold written values; the control A and B mirrors only trusted while sync clocking runs
  reg [7:0] irq_en_r;
  reg [7:0] ctla_r;
  reg [7:0] ctlb_r;
  reg ext_r;
  reg asel_r;
  always @(posedge ref_clk) begin
    if (rst) begin
      irq_en_r <= 8'h00;
      ctla_r <= 8'h00;
      ctlb_r <= 8'h00;
      ext_r <= 1'b0;
      asel_r <= 1'b0;
    end else if (wr_en) begin
      if (addr == `OFS_IRQ_ENABLE) irq_en_r <= wdata;
      if (addr == `OFS_CTRL_A) ctla_r <= wdata;
      if (addr == `OFS_CTRL_B) ctlb_r <= wdata;
      if (addr == `OFS_ASYNC) begin
        ext_r <= wdata[6];
        asel_r <= wdata[5];
      end
    end
  end
  wire [2:0] mode_w = {wdata[3], ctla_r[1:0]};
  wire npwm_w = (mode_w == 3'h0) || (mode_w == 3'h2);
  // force write with the counter held stopped, so no real match interferes
  wire force_w = wr_en && addr == `OFS_CTRL_B && wdata[7] && !asel_r &&
    ctlb_r[2:0] == 3'h0 && wdata[2:0] == 3'h0;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_irq_a_gate: assert property (
    irq_compare_a |-> global_irq_enable && irq_en_r[1])
    else $error("compare A request without its enables");
  a_irq_b_gate: assert property (
    irq_compare_b |-> global_irq_enable && irq_en_r[2])
    else $error("compare B request without its enables");
  a_irq_ovf_gate: assert property (
    irq_overflow |-> global_irq_enable && irq_en_r[0])
    else $error("overflow request without its enables");
  a_ctlb_read_zero: assert property (
    rd_en && addr == `OFS_CTRL_B |=> rdata[7:4] == 4'h0)
    else $error("control B upper bits read nonzero");
  a_osc_run: assert property (
    osc_run == (asel_r && !ext_r))
    else $error("crystal enable disagrees with async status");
  a_ext_buf: assert property (
    ext_clk_buf_en == (asel_r && ext_r))
    else $error("external clock buffer disagrees with async status");
  a_force_toggle: assert property (
    force_w && npwm_w && ctla_r[7:6] == 2'h1 |-> ##[1:2] $changed(wave_out_a))
    else $error("forced toggle did not change output A");
  a_force_pwm_off: assert property (
    force_w && !npwm_w && ctla_r[7:6] != 2'h0 |=> $stable(wave_out_a) [*2])
    else $error("force acted in a PWM mode");
  a_busy_sync: assert property (
    rd_en && addr == `OFS_ASYNC && !asel_r |=> rdata[4:0] == 5'h00)
    else $error("busy flag seen with sync clocking");

  c_force: cover property (force_w);
  c_ovf_irq: cover property (irq_overflow);
  c_async_read: cover property (rd_en && addr == `OFS_ASYNC && asel_r);
endmodule

bind async_timer2 timer2_checker chk (
  .ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata),
  .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
  .global_irq_enable(global_irq_enable), .irq_compare_b(irq_compare_b),
  .irq_compare_a(irq_compare_a), .irq_overflow(irq_overflow),
  .osc_run(osc_run), .ext_clk_buf_en(ext_clk_buf_en),
  .wave_out_a(wave_out_a)
);

// ### tb/tb.sv
// self-checking bench for the async timer block
// assumes the byte register port and a slow oscillator pin pulse
`timescale 1ns/1ps
`include "timer2_consts.vh"

module tb;
  reg ref_clk = 1'b0;
  reg rst = 1'b1;
  reg [7:0] addr = 8'h00;
  reg [7:0] wdata = 8'h00;
  reg wr_en = 1'b0;
  reg rd_en = 1'b0;
  reg global_irq_enable = 1'b0;
  reg [2:0] vector_ack = 3'h0;
  reg osc_input_pin = 1'b0;
  wire [7:0] rdata;
  wire irq_compare_b, irq_compare_a, irq_overflow, osc_run, ext_clk_buf_en;
  wire wave_out_a, wave_out_a_oe, wave_out_b, wave_out_b_oe;
  wire [7:0] irqs = {5'h00, irq_compare_b, irq_compare_a, irq_overflow};
  integer fail_count = 0;
  integer n_checks = 0;

  always #5 ref_clk = ~ref_clk;

  async_timer2 DUT (
    .ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .global_irq_enable(global_irq_enable), .vector_ack(vector_ack),
    .irq_compare_b(irq_compare_b), .irq_compare_a(irq_compare_a),
    .irq_overflow(irq_overflow), .osc_input_pin(osc_input_pin),
    .osc_run(osc_run), .ext_clk_buf_en(ext_clk_buf_en),
    .wave_out_a(wave_out_a), .wave_out_a_oe(wave_out_a_oe),
    .wave_out_b(wave_out_b), .wave_out_b_oe(wave_out_b_oe)
  );

  // ----------------------------------------
  // bus and compare helpers
  // ----------------------------------------
  task check(input [7:0] seen, input [7:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // the #1 lets the block's register updates land before any look
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge ref_clk);
      wr_en <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge ref_clk);
      wr_en <= 1'b0;
      #1;
    end
  endtask
  task rd(input [7:0] a, output [7:0] d);
    begin
      @(posedge ref_clk);
      rd_en <= 1'b1;
      addr <= a;
      @(posedge ref_clk);
      rd_en <= 1'b0;
      #1 d = rdata;
    end
  endtask
  task rdck(input [7:0] a, input [7:0] exp);
    reg [7:0] d;
    begin
      rd(a, d);
      check(d, exp);
    end
  endtask
  // stopping waits so a tick already in the divider cannot land late
  task stop;
    begin
      wr(`OFS_CTRL_B, 8'h00);
      repeat (4) @(posedge ref_clk);
    end
  endtask
  function integer ratio(input integer s);
    case (s)
      2: ratio = 8;
      3: ratio = 32;
      4: ratio = 64;
      5: ratio = 128;
      6: ratio = 256;
      7: ratio = 1024;
      default: ratio = 1;
    endcase
  endfunction

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_reset;
    begin
      rdck(`OFS_IRQ_ENABLE, 8'h00);
      rdck(`OFS_CTRL_A, 8'h00);
      rdck(`OFS_CTRL_B, 8'h00);
      rdck(`OFS_COUNT, 8'h00);
      rdck(`OFS_ASYNC, 8'h00);
      rdck(`OFS_FLAGS, 8'h00);
      wr(`OFS_IRQ_ENABLE, 8'hFF);
      rdck(`OFS_IRQ_ENABLE, 8'h07);
      wr(`OFS_IRQ_ENABLE, 8'h00);
      wr(`OFS_ASYNC, 8'h9F);
      rdck(`OFS_ASYNC, 8'h00);
      wr(8'h55, 8'hFF);
      rdck(8'h55, 8'h00);
      wr(`OFS_CTRL_B, 8'hF8);
      rdck(`OFS_CTRL_B, 8'h08);
      wr(`OFS_CTRL_B, 8'h00);
    end
  endtask
  // reads spaced by exactly three divided periods must differ by three, or by zero with code 0
  task t_prescale;
    integer s;
    reg [7:0] a;
    reg [7:0] b;
    begin
      wr(`OFS_COUNT, 8'hA5);
      rdck(`OFS_COUNT, 8'hA5);
      for (s = 0; s < 8; s = s + 1) begin
        wr(`OFS_CTRL_B, s[7:0]);
        rd(`OFS_COUNT, a);
        repeat (3 * ratio(s) - 2) @(posedge ref_clk);
        rd(`OFS_COUNT, b);
        check(b - a, (s == 0) ? 8'h00 : 8'h03);
      end
      stop;
    end
  endtask
  task t_match;
    begin
      wr(`OFS_CMP_A, 8'h20);
      wr(`OFS_COUNT, 8'h20);
      wr(`OFS_FLAGS, 8'h07);
      wr(`OFS_CTRL_B, 8'h02);
      repeat (20) @(posedge ref_clk);
      stop;
      rdck(`OFS_FLAGS, 8'h00);
      wr(`OFS_IRQ_ENABLE, 8'h07);
      @(posedge ref_clk) global_irq_enable <= 1'b1;
      wr(`OFS_CTRL_B, 8'h01);
      repeat (300) @(posedge ref_clk);
      stop;
      rdck(`OFS_FLAGS, 8'h07);
      check(irqs, 8'h07);
      @(posedge ref_clk) global_irq_enable <= 1'b0;
      #1 check(irqs, 8'h00);
      @(posedge ref_clk) global_irq_enable <= 1'b1;
      @(posedge ref_clk) vector_ack <= 3'h2;
      @(posedge ref_clk) vector_ack <= 3'h0;
      rdck(`OFS_FLAGS, 8'h05);
      wr(`OFS_FLAGS, 8'h05);
      rdck(`OFS_FLAGS, 8'h00);
      check(irqs, 8'h00);
      wr(`OFS_IRQ_ENABLE, 8'h00);
    end
  endtask
  task t_force;
    integer i;
    reg [1:0] act;
    reg e;
    begin
      e = 1'b0;
      for (i = 0; i < 5; i = i + 1) begin
        act = (i == 0 || i == 4) ? 2'h2 : (i == 3) ? 2'h3 : 2'h1;
        wr(`OFS_CTRL_A, {act, act, 4'h0});
        check({6'h00, wave_out_a_oe, wave_out_b_oe}, 8'h03);
        wr(`OFS_CTRL_B, 8'hC0);
        repeat (2) @(posedge ref_clk);
        e = (act == 2'h2) ? 1'b0 : (act == 2'h3) ? 1'b1 : ~e;
        check({6'h00, wave_out_a, wave_out_b}, {6'h00, e, e});
      end
      wr(`OFS_CTRL_A, 8'h42);
      wr(`OFS_COUNT, 8'h20);
      wr(`OFS_CTRL_B, 8'h80);
      repeat (2) @(posedge ref_clk);
      check({7'h00, wave_out_a}, 8'h01);
      rdck(`OFS_COUNT, 8'h20);
      rdck(`OFS_FLAGS, 8'h00);
      // fast PWM: a forced clear must leave the output high
      wr(`OFS_CTRL_A, 8'h83);
      wr(`OFS_CTRL_B, 8'h80);
      repeat (2) @(posedge ref_clk);
      check({7'h00, wave_out_a}, 8'h01);
      wr(`OFS_CTRL_B, 8'h00);
      wr(`OFS_CTRL_A, 8'h00);
      wr(`OFS_COUNT, 8'h00);
    end
  endtask
  // TOP = 4 in CTC, phase-correct and fast PWM: the count repeats after
  // one period, and only the PWM modes raise the overflow flag
  task t_modes;
    integer m;
    reg [7:0] a;
    reg [7:0] b;
    begin
      wr(`OFS_CMP_A, 8'h04);
      wr(`OFS_CMP_B, 8'h80);
      for (m = 0; m < 3; m = m + 1) begin
        wr(`OFS_CTRL_A, (m == 0) ? 8'h02 : (m == 1) ? 8'h01 : 8'h03);
        wr(`OFS_COUNT, 8'h00);
        wr(`OFS_FLAGS, 8'h07);
        wr(`OFS_CTRL_B, (m == 0) ? 8'h01 : 8'h09);
        rd(`OFS_COUNT, a);
        repeat ((m == 1) ? 6 : 3) @(posedge ref_clk);
        rd(`OFS_COUNT, b);
        stop;
        check(b, a);
        check({7'h00, a <= 8'h04}, 8'h01);
        rdck(`OFS_FLAGS, (m == 0) ? 8'h02 : 8'h03);
      end
      wr(`OFS_CTRL_A, 8'h00);
      wr(`OFS_COUNT, 8'h00);
    end
  endtask
  task t_async;
    begin
      wr(`OFS_ASYNC, 8'h40);
      check({6'h00, osc_run, ext_clk_buf_en}, 8'h00);
      wr(`OFS_ASYNC, 8'h60);
      check({6'h00, osc_run, ext_clk_buf_en}, 8'h01);
      wr(`OFS_CTRL_A, 8'h00);
      wr(`OFS_CTRL_B, 8'h00);
      wr(`OFS_CMP_A, 8'h04);
      wr(`OFS_CMP_B, 8'h33);
      wr(`OFS_COUNT, 8'h44);
      rdck(`OFS_ASYNC, 8'h7F);
      rdck(`OFS_CMP_B, 8'h33);
      rdck(`OFS_COUNT, 8'h00);
      // one pin edge moves the held values; no write until busy clears
      @(posedge ref_clk) osc_input_pin <= 1'b1;
      repeat (6) @(posedge ref_clk);
      osc_input_pin <= 1'b0;
      repeat (6) @(posedge ref_clk);
      rdck(`OFS_ASYNC, 8'h60);
      rdck(`OFS_COUNT, 8'h44);
      wr(`OFS_ASYNC, 8'h20);
      check({6'h00, osc_run, ext_clk_buf_en}, 8'h02);
      wr(`OFS_ASYNC, 8'h00);
      check({6'h00, osc_run, ext_clk_buf_en}, 8'h00);
      wr(`OFS_CMP_A, 8'h00);
      wr(`OFS_CMP_B, 8'h00);
      wr(`OFS_COUNT, 8'h00);
    end
  endtask

  // ----------------------------------------
  // run control
  // ----------------------------------------
  task wrap_up;
    begin
      if (fail_count == 0 && n_checks > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask

  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset;
    t_prescale;
    t_match;
    t_force;
    t_modes;
    t_async;
    wrap_up;
  end

  // the full sequence needs about 5200 cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count = fail_count + 1;
    wrap_up;
  end
endmodule
